// >>> rtl/reader_timer_pkg.sv
// Constants for the reader interrupt, timer and soft power-down block.
// Assumes a 100 MHz system clock and an 8-bit register port.
package reader_timer_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_CMD    = 8'h01;
   localparam logic [7:0] ADDR_IEN    = 8'h02;
   localparam logic [7:0] ADDR_IEN2   = 8'h03;
   localparam logic [7:0] ADDR_COMM   = 8'h04;
   localparam logic [7:0] ADDR_MISC   = 8'h05;
   localparam logic [7:0] ADDR_ERR    = 8'h06;
   localparam logic [7:0] ADDR_STAT   = 8'h07;
   localparam logic [7:0] ADDR_THRESH = 8'h0B;
   localparam logic [7:0] ADDR_CTRL   = 8'h0C;
   localparam logic [7:0] ADDR_DEMOD  = 8'h19;
   localparam logic [7:0] ADDR_TMODE  = 8'h2A;
   localparam logic [7:0] ADDR_TPRE   = 8'h2B;
   localparam logic [7:0] ADDR_RLD_HI = 8'h2C;
   localparam logic [7:0] ADDR_RLD_LO = 8'h2D;
   localparam logic [7:0] ADDR_CNT_HI = 8'h2E;
   localparam logic [7:0] ADDR_CNT_LO = 8'h2F;

   // Field positions
   localparam int unsigned FLAG_TIMER  = 0;
   localparam int unsigned FLAG_ERR    = 1;
   localparam int unsigned FLAG_LOW    = 2;
   localparam int unsigned FLAG_HIGH   = 3;
   localparam int unsigned FLAG_IDLE   = 4;
   localparam int unsigned FLAG_RX     = 5;
   localparam int unsigned FLAG_TX     = 6;
   localparam int unsigned FLAG_SET    = 7;
   localparam int unsigned MISC_CRC    = 2;
   localparam int unsigned STAT_LOW    = 0;
   localparam int unsigned STAT_HIGH   = 1;
   localparam int unsigned STAT_RUN    = 3;
   localparam int unsigned STAT_IRQ    = 4;
   localparam int unsigned STAT_CRC    = 5;
   localparam int unsigned CMD_SLEEP   = 4;
   localparam int unsigned CTRL_START  = 6;
   localparam int unsigned CTRL_STOP   = 7;
   localparam int unsigned TMODE_AUTO  = 7;
   localparam int unsigned TMODE_RSTRT = 4;
   localparam int unsigned DEMOD_EVEN  = 4;

   // Reset values and codes
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam logic [5:0] THRESH_RESET = 6'h08;
   localparam logic [3:0] CMD_IDLE     = 4'h0;
   localparam logic [6:0] FIFO_DEPTH   = 7'h40;

   // Timer clock derived from the system clock by a phase accumulator
   localparam int unsigned CLK_HZ   = 100_000_000;
   localparam int unsigned TICK_HZ  = 13_560_000;
   localparam int unsigned ACC_GCD  = 10_000;
   localparam logic [13:0] ACC_STEP = 14'(TICK_HZ / ACC_GCD);
   localparam logic [13:0] ACC_MOD  = 14'(CLK_HZ / ACC_GCD);

   // Wake-up delay after clearing the sleep bit
   localparam int unsigned WAKE_CLOCKS = 1024;
   localparam logic [10:0] WAKE_LAST   = 11'(WAKE_CLOCKS - 1);

   typedef enum logic [1:0] {
      AWAKE  = 2'b00,
      ASLEEP = 2'b01,
      WAKING = 2'b10
   } sleep_e;

endpackage

// >>> rtl/reader_irq_timer.sv
// Interrupt flags, two-stage timer and soft power-down of a reader chip.
// Assumes event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: Events set sticky flags; summary bit in status, enabled ones drive irq.
// RULE2: Timer flag sets when counter steps from one to zero.
// RULE3: Transmit-done flag sets on end-of-frame pattern start.
// RULE4: CRC flag sets when CRC result becomes valid.
// RULE5: Receive-done flag sets at end of incoming stream.
// RULE6: Command-finished flag sets when command field returns to idle.
// RULE7: FIFO warn flags set on rising nearly-full and nearly-empty status.
// RULE8: Error flag sets while any error bit is high during transfer.
// RULE9: Timer ticks at 13.56 MHz; prescaler then counter stage.
// RULE10: Twelve-bit prescaler reload, upper four bits in timer mode register.
// RULE11: Counter reloads from a sixteen-bit host value.
// RULE12: Present counter value readable by the host.
// RULE13: Host may set or clear the timer flag by write.
// RULE14: At zero the counter halts or reloads, per configuration.
// RULE15: Start and stop commands control the timer; running bit reports it.
// RULE16: Autostart mode starts the timer on protocol events.
// RULE17: Each stage lasts reload plus one; prescaler period is odd. Here the prescaler stage lasts twice its reload plus one.
// RULE18: Even-period option adds one tick to every prescaler period.
// RULE19: Timer expiry changes nothing except its own flag.
// RULE20: Sleep bit enters soft power-down at once, state kept.
// RULE21: After clearing, sleep bit reads one for 1024 clocks.
// RULE22: Host polls address zero after wake-up before other access.
// RULE23: Nearly-full when free space within threshold; nearly-empty when level within.
// RULE24: Irq pin high while any enabled flag is set; irq holds its last value while osc_stop is high.
module reader_irq_timer (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       tx_eof,
   input  wire logic       rx_end,
   input  wire logic       crc_valid,
   input  wire logic       cmd_done,
   input  wire logic       xfer_active,
   input  wire logic [7:0] err_bits,
   input  wire logic [6:0] fifo_level,
   input  wire logic       proto_event,
   output logic            irq,
   output logic            osc_stop,
   output logic      [3:0] command,
   output logic            timer_active
);
   import reader_timer_pkg::*;

   logic [13:0] acc,        next_acc;
   logic [12:0] presc,      next_presc;
   logic [15:0] count,      next_count;
   logic        next_run;
   logic        tick;
   logic        timer_hit;
   logic [12:0] presc_load;
   sleep_e      sleep,      next_sleep;
   logic [10:0] wake_cnt,   next_wake_cnt;
   logic        next_osc_stop;
   logic [3:0]  next_command;
   logic [7:0]  ien,        next_ien;
   logic [7:0]  ien2,       next_ien2;
   logic [6:0]  comm,       next_comm;
   logic        crc_flag,   next_crc_flag;
   logic [5:0]  thresh,     next_thresh;
   logic [7:0]  tmode,      next_tmode;
   logic [7:0]  tpre,       next_tpre;
   logic [15:0] rld,        next_rld;
   logic        even,       next_even;
   logic        high,       next_high;
   logic        low,        next_low;
   logic        crc_prev;
   logic        next_irq;
   logic [7:0]  next_rdata;
   logic        pending;
   logic        wr_cmd;
   logic        wr_comm;
   logic        wr_misc;
   logic        start_cmd;
   logic        stop_cmd;
   logic [6:0]  hw_set;
   logic [6:0]  sw_set;
   logic [6:0]  sw_clr;

   assign wr_cmd    = wr && (addr == ADDR_CMD);
   assign wr_comm   = wr && (addr == ADDR_COMM);
   assign wr_misc   = wr && (addr == ADDR_MISC);
   assign start_cmd = wr && (addr == ADDR_CTRL) && wdata[CTRL_START];
   assign stop_cmd  = wr && (addr == ADDR_CTRL) && wdata[CTRL_STOP];

   // Timer and tick divider
   always_comb begin
      next_acc   = acc;
      tick       = 1'b0;
      next_run   = timer_active;
      next_presc = presc;
      next_count = count;
      timer_hit  = 1'b0;
      // RULE10 RULE17 RULE18 prescaler period
      presc_load = {tmode[3:0], tpre, 1'b0} | {12'h000, even};
      // RULE9 tick from divider
      if (sleep == AWAKE) begin
         if (acc >= (ACC_MOD - ACC_STEP)) begin
            next_acc = acc - (ACC_MOD - ACC_STEP);
            tick     = 1'b1;
         end else begin
            next_acc = acc + ACC_STEP;
         end
      end
      // RULE15 RULE16 start and stop
      if (stop_cmd) begin
         next_run = 1'b0;
      end else if (start_cmd || (tmode[TMODE_AUTO] && proto_event)) begin
         next_run   = 1'b1;
         next_presc = presc_load;
         // RULE11 counter reload
         next_count = rld;
      end else if (timer_active && tick) begin
         if (presc == 13'h0000) begin
            next_presc = presc_load;
            if (count == 16'h0001) begin
               // RULE2 one to zero
               next_count = 16'h0000;
               timer_hit  = 1'b1;
               // RULE14 halt at zero unless restarting
               next_run   = tmode[TMODE_RSTRT];
            end else if (count == 16'h0000) begin
               // RULE14 reload and continue
               next_count = rld;
            end else begin
               next_count = count - 16'h0001;
            end
         end else begin
            next_presc = presc - 13'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc          <= '0;
         presc        <= '0;
         count        <= '0;
         timer_active <= 1'b0;
      end else begin
         acc          <= next_acc;
         presc        <= next_presc;
         count        <= next_count;
         timer_active <= next_run;
      end
   end

   // Soft power-down sequence
   always_comb begin
      next_sleep    = sleep;
      next_wake_cnt = wake_cnt;
      case (sleep)
         AWAKE: begin
            // RULE20 enter at once
            if (wr_cmd && wdata[CMD_SLEEP]) begin
               next_sleep = ASLEEP;
            end
         end
         ASLEEP: begin
            if (wr_cmd && !wdata[CMD_SLEEP]) begin
               next_sleep    = WAKING;
               next_wake_cnt = '0;
            end
         end
         WAKING: begin
            // RULE21 delayed exit
            if (wr_cmd && wdata[CMD_SLEEP]) begin
               next_sleep = ASLEEP;
            end else if (wake_cnt == WAKE_LAST) begin
               next_sleep = AWAKE;
            end else begin
               next_wake_cnt = wake_cnt + 11'h001;
            end
         end
         default: next_sleep = AWAKE;
      endcase
      next_osc_stop = (next_sleep != AWAKE);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep    <= AWAKE;
         wake_cnt <= '0;
         osc_stop <= 1'b0;
      end else begin
         sleep    <= next_sleep;
         wake_cnt <= next_wake_cnt;
         osc_stop <= next_osc_stop;
      end
   end

   // Flags, configuration and read port
   always_comb begin
      next_command  = command;
      next_ien      = ien;
      next_ien2     = ien2;
      next_thresh   = thresh;
      next_tmode    = tmode;
      next_tpre     = tpre;
      next_rld      = rld;
      next_even     = even;
      next_rdata    = REG_RESET;
      // RULE23 FIFO level compares
      next_high     = ((FIFO_DEPTH - fifo_level) <= {1'b0, thresh});
      next_low      = (fifo_level <= {1'b0, thresh});
      hw_set        = '0;
      // RULE2 RULE19 timer only touches its flag
      hw_set[FLAG_TIMER] = timer_hit;
      // RULE8 error during transfer
      hw_set[FLAG_ERR]   = (|err_bits) && xfer_active;
      // RULE7 rising warnings
      hw_set[FLAG_LOW]   = next_low && !low;
      hw_set[FLAG_HIGH]  = next_high && !high;
      // RULE6 command finished
      hw_set[FLAG_IDLE]  = cmd_done;
      // RULE5 receive done
      hw_set[FLAG_RX]    = rx_end;
      // RULE3 transmit done
      hw_set[FLAG_TX]    = tx_eof;
      // RULE13 host set or clear
      sw_set = (wr_comm && wdata[FLAG_SET]) ? wdata[6:0] : 7'h00;
      sw_clr = (wr_comm && !wdata[FLAG_SET]) ? wdata[6:0] : 7'h00;
      // Hardware set wins over a same-cycle clear
      next_comm = (comm & ~sw_clr) | sw_set | hw_set;
      next_crc_flag = crc_flag;
      if (wr_misc && wdata[MISC_CRC]) begin
         next_crc_flag = wdata[FLAG_SET];
      end
      // RULE4 CRC result valid
      if (crc_valid && !crc_prev) begin
         next_crc_flag = 1'b1;
      end
      if (wr) begin
         case (addr)
            ADDR_CMD:    next_command = wdata[3:0];
            ADDR_IEN:    next_ien     = wdata;
            ADDR_IEN2:   next_ien2    = wdata;
            ADDR_THRESH: next_thresh  = wdata[5:0];
            ADDR_TMODE:  next_tmode   = wdata;
            ADDR_TPRE:   next_tpre    = wdata;
            ADDR_RLD_HI: next_rld     = {wdata, rld[7:0]};
            ADDR_RLD_LO: next_rld     = {rld[15:8], wdata};
            ADDR_DEMOD:  next_even    = wdata[DEMOD_EVEN];
            default:     next_command = command;
         endcase
      end
      // RULE6 return to idle
      if (cmd_done) begin
         next_command = CMD_IDLE;
      end
      // RULE24 enabled flags
      pending  = (|(comm & ien[6:0])) || (crc_flag && ien2[MISC_CRC]);
      // RULE20 irq output holds during sleep
      next_irq = osc_stop ? irq : pending;
      if (rd) begin
         case (addr)
            ADDR_CMD:    next_rdata = {3'b000, osc_stop, command};
            ADDR_IEN:    next_rdata = ien;
            ADDR_IEN2:   next_rdata = ien2;
            ADDR_COMM:   next_rdata = {1'b0, comm};
            ADDR_MISC:   next_rdata = {5'b00000, crc_flag, 2'b00};
            ADDR_ERR:    next_rdata = err_bits;
            ADDR_STAT: begin
               // RULE1 RULE15 status summary
               next_rdata            = REG_RESET;
               next_rdata[STAT_LOW]  = low;
               next_rdata[STAT_HIGH] = high;
               next_rdata[STAT_RUN]  = timer_active;
               // Summary ignores the enables; only the pin is masked
               next_rdata[STAT_IRQ]  = (|comm) || crc_flag;
               next_rdata[STAT_CRC]  = crc_valid;
            end
            ADDR_THRESH: next_rdata = {2'b00, thresh};
            ADDR_DEMOD:  next_rdata = {3'b000, even, 4'h0};
            ADDR_TMODE:  next_rdata = tmode;
            ADDR_TPRE:   next_rdata = tpre;
            ADDR_RLD_HI: next_rdata = rld[15:8];
            ADDR_RLD_LO: next_rdata = rld[7:0];
            // RULE12 live counter value
            ADDR_CNT_HI: next_rdata = count[15:8];
            ADDR_CNT_LO: next_rdata = count[7:0];
            default:     next_rdata = REG_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         command  <= CMD_IDLE;
         ien      <= REG_RESET;
         ien2     <= REG_RESET;
         comm     <= '0;
         crc_flag <= 1'b0;
         thresh   <= THRESH_RESET;
         tmode    <= REG_RESET;
         tpre     <= REG_RESET;
         rld      <= '0;
         even     <= 1'b0;
         high     <= 1'b0;
         low      <= 1'b0;
         crc_prev <= 1'b0;
         irq      <= 1'b0;
         rdata    <= REG_RESET;
      end else begin
         command  <= next_command;
         ien      <= next_ien;
         ien2     <= next_ien2;
         comm     <= next_comm;
         crc_flag <= next_crc_flag;
         thresh   <= next_thresh;
         tmode    <= next_tmode;
         tpre     <= next_tpre;
         rld      <= next_rld;
         even     <= next_even;
         high     <= next_high;
         low      <= next_low;
         crc_prev <= crc_valid;
         irq      <= next_irq;
         rdata    <= next_rdata;
      end
   end

   // Checks
   property p_irq_follows;
      @(posedge clk) disable iff (!rstn) !osc_stop |=> (irq == $past(pending));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq does not follow enabled flags"); // RULE24
   property p_timer_flag;
      @(posedge clk) disable iff (!rstn) timer_hit |=> comm[FLAG_TIMER] && (count == 16'h0000);
   endproperty
   a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set at zero"); // RULE2
   property p_tx_flag;
      @(posedge clk) disable iff (!rstn) tx_eof |=> comm[FLAG_TX];
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("transmit flag lost"); // RULE3
   property p_rx_flag;
      @(posedge clk) disable iff (!rstn) rx_end |=> comm[FLAG_RX];
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("receive flag lost"); // RULE5
   property p_idle;
      @(posedge clk) disable iff (!rstn) cmd_done |=> comm[FLAG_IDLE] && (command == CMD_IDLE);
   endproperty
   a_idle: assert property (p_idle) else $error("command not back to idle"); // RULE6
   property p_crc;
      @(posedge clk) disable iff (!rstn) $rose(crc_valid) |=> crc_flag;
   endproperty
   a_crc: assert property (p_crc) else $error("crc flag not set"); // RULE4
   property p_err;
      @(posedge clk) disable iff (!rstn) ((|err_bits) && xfer_active) |=> comm[FLAG_ERR];
   endproperty
   a_err: assert property (p_err) else $error("error flag not set"); // RULE8
   property p_high;
      @(posedge clk) disable iff (!rstn) $rose(high) |-> comm[FLAG_HIGH];
   endproperty
   a_high: assert property (p_high) else $error("nearly full flag not set"); // RULE7
   property p_sleep_enter;
      @(posedge clk) disable iff (!rstn) (wr_cmd && wdata[CMD_SLEEP]) |=> osc_stop;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered at once"); // RULE20
   property p_wake_hold;
      @(posedge clk) disable iff (!rstn) (sleep == ASLEEP && wr_cmd && !wdata[CMD_SLEEP]) |=> osc_stop [*8];
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("sleep bit cleared early"); // RULE21
   property p_wake_exit;
      @(posedge clk) disable iff (!rstn) (sleep == WAKING && wake_cnt == WAKE_LAST && !wr_cmd) |=> !osc_stop;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("sleep not left after delay"); // RULE21
   property p_stop;
      @(posedge clk) disable iff (!rstn) stop_cmd |=> !timer_active;
   endproperty
   a_stop: assert property (p_stop) else $error("timer did not stop"); // RULE15
   property p_halt;
      @(posedge clk) disable iff (!rstn) (timer_hit && !tmode[TMODE_RSTRT] && !start_cmd) |=> !timer_active;
   endproperty
   a_halt: assert property (p_halt) else $error("timer did not halt at zero"); // RULE14
   property p_host_set;
      @(posedge clk) disable iff (!rstn) (wr_comm && wdata[FLAG_SET] && wdata[FLAG_TIMER]) |=> comm[FLAG_TIMER];
   endproperty
   a_host_set: assert property (p_host_set) else $error("host set of timer flag failed"); // RULE13

   c_timer_hit: cover property (@(posedge clk) disable iff (!rstn) timer_hit);
   c_wake_done: cover property (@(posedge clk) disable iff (!rstn) $fell(osc_stop));
   c_irq_rise:  cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
   c_autostart: cover property (@(posedge clk) disable iff (!rstn) tmode[TMODE_AUTO] && proto_event);

endmodule

`default_nettype wire

// >>> bench/host_model.sv
// Host controller model: drives the register port of the reader block.
// Assumes one-cycle read latency and a slave that never waits.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd,
   input  wire logic [7:0] rdata
);
   initial begin
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   task automatic wr_r(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~v;
   endtask
   task automatic rd_r(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic poll0(output int n);
      logic [7:0] v;
      n = 0;
      wr_r(8'h00, 8'h55);
      do begin
         rd_r(8'h00, v);
         n++;
      end while (v !== 8'h00 && n < 64);
   endtask
endmodule
`default_nettype wire

// >>> bench/reader_irq_timer_tb.sv
// Self-checking bench for the reader flag, timer and sleep block.
// Assumes the package offsets and the host model on the register port.
`timescale 1ns/1ps
`default_nettype none
module reader_irq_timer_tb;
   import reader_timer_pkg::*;
   logic       clk, rstn, tx_eof, rx_end, crc_valid, cmd_done, xfer_active, proto_event;
   logic       wr, rd, irq, osc_stop, timer_active;
   logic [7:0] addr, wdata, rdata, err_bits, d;
   logic [6:0] fifo_level;
   logic [3:0] command;
   int         n_fail = 0;
   int         compares = 0;
   int         cyc = 0;
   int         k, n, e, t0;
   localparam logic [7:0] EA [4] = '{ADDR_COMM, ADDR_COMM, ADDR_COMM, ADDR_MISC};
   localparam int         EB [4] = '{FLAG_TX, FLAG_RX, FLAG_IDLE, MISC_CRC};

   host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   reader_irq_timer i_dut (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tx_eof(tx_eof), .rx_end(rx_end), .crc_valid(crc_valid), .cmd_done(cmd_done),
      .xfer_active(xfer_active), .err_bits(err_bits), .fifo_level(fifo_level),
      .proto_event(proto_event), .irq(irq), .osc_stop(osc_stop), .command(command),
      .timer_active(timer_active));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      compares++;
      if (s !== x) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic complete_run();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Timer model: counter stage lasts its reload plus one, prescaler stage twice its reload plus one plus ev_m
   function automatic int t_ticks(input int p, input int r, input int ev_m);
      return (2 * p + 1 + ev_m) * (r + 1);
   endfunction
   task automatic ev(input int s);
      @(posedge clk);
      tx_eof      <= (s == 0);
      rx_end      <= (s == 1);
      cmd_done    <= (s == 2);
      crc_valid   <= (s == 3);
      proto_event <= (s == 4);
      @(posedge clk);
      {tx_eof, rx_end, cmd_done, crc_valid, proto_event} <= 5'h00;
   endtask
   // Waits for irq, stamps the cycle, clears the timer flag
   task automatic wait_irq(output int t);
      int i;
      for (i = 0; i < 3000 && irq !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(irq, 1'b1);
      t = cyc;
      i_host.wr_r(ADDR_COMM, 8'h01);
      repeat (3) @(posedge clk);
      #1;
   endtask

   initial begin
      rstn = 1'b0;
      {tx_eof, rx_end, cmd_done, crc_valid, proto_event, xfer_active} = 6'h00;
      err_bits = 8'h00;
      fifo_level = 7'h20;
      k = $urandom(32'hE023);
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      i_host.rd_r(ADDR_THRESH, d);
      chk(d, {2'b00, THRESH_RESET});
      i_host.wr_r(8'h00, 8'hA5);
      i_host.rd_r(8'h00, d);
      chk(d, 8'h00);
      $display("test reset done");
      i_host.wr_r(ADDR_COMM, 8'h7F);
      i_host.wr_r(ADDR_IEN, 8'h7F);
      i_host.wr_r(ADDR_IEN2, 8'h04);
      for (k = 0; k < 4; k++) begin
         ev(k);
         i_host.rd_r(EA[k], d);
         chk(d, 16'(8'h01 << EB[k]));
         chk(irq, 1'b1);
         i_host.rd_r(ADDR_STAT, d);
         chk(d[STAT_IRQ], 1'b1);
         i_host.wr_r(EA[k], 8'h7F);
         repeat (2) @(posedge clk);
         #1 chk(irq, 1'b0);
      end
      i_host.wr_r(ADDR_IEN, 8'h3F);
      ev(0);
      repeat (3) @(posedge clk);
      #1 chk(irq, 1'b0);
      i_host.rd_r(ADDR_STAT, d);
      chk(d[STAT_IRQ], 1'b1);
      i_host.wr_r(ADDR_COMM, 8'h7F);
      $display("test events done");
      for (k = 0; k < 6; k++) begin
         e = $urandom % 64;
         n = $urandom % 65;
         i_host.wr_r(ADDR_THRESH, 8'(e));
         fifo_level <= 7'(n);
         i_host.rd_r(ADDR_STAT, d);
         chk(d[1:0], {1'(64 - n <= e), 1'(n <= e)});
      end
      i_host.wr_r(ADDR_THRESH, 8'h08);
      fifo_level <= 7'h20;
      i_host.wr_r(ADDR_COMM, 8'h7F);
      fifo_level <= 7'h3C;
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h08);
      fifo_level <= 7'h04;
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h0C);
      fifo_level <= 7'h20;
      err_bits <= 8'($urandom) | 8'h01;
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h0C);
      xfer_active <= 1'b1;
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h0E);
      {xfer_active, err_bits} <= 9'h000;
      i_host.wr_r(ADDR_COMM, 8'h7F);
      $display("test fifo and error done");
      i_host.wr_r(ADDR_IEN, 8'h01);
      i_host.wr_r(ADDR_TPRE, 8'h02);
      i_host.wr_r(ADDR_RLD_LO, 8'h03);
      for (k = 0; k < 2; k++) begin
         i_host.wr_r(ADDR_TMODE, 8'h10);
         i_host.wr_r(ADDR_DEMOD, k ? 8'h10 : 8'h00);
         i_host.wr_r(ADDR_CTRL, 8'h40);
         wait_irq(t0);
         wait_irq(n);
         e = t_ticks(2, 3, k) * 10000 / 1356;
         chk(n - t0 >= e - 8 && n - t0 <= e + 8, 1'b1);
         chk(timer_active, 1'b1);
         i_host.wr_r(ADDR_CTRL, 8'hC0);
         repeat (2) @(posedge clk);
         #1 chk(timer_active, 1'b0);
      end
      i_host.wr_r(ADDR_TMODE, 8'h01);
      i_host.wr_r(ADDR_TPRE, 8'hFF);
      i_host.wr_r(ADDR_RLD_HI, 8'h02);
      i_host.wr_r(ADDR_CTRL, 8'h40);
      i_host.rd_r(ADDR_CNT_HI, d);
      chk(d, 8'h02);
      i_host.rd_r(ADDR_CNT_LO, d);
      chk(d, 8'h03);
      i_host.rd_r(ADDR_STAT, d);
      chk(d[STAT_RUN], 1'b1);
      i_host.wr_r(ADDR_CTRL, 8'h80);
      i_host.rd_r(ADDR_STAT, d);
      chk(d[STAT_RUN], 1'b0);
      i_host.wr_r(ADDR_TMODE, 8'h00);
      i_host.wr_r(ADDR_TPRE, 8'h00);
      i_host.wr_r(ADDR_RLD_HI, 8'h00);
      i_host.wr_r(ADDR_RLD_LO, 8'h02);
      i_host.wr_r(ADDR_CMD, 8'h03);
      i_host.wr_r(ADDR_CTRL, 8'h40);
      wait_irq(t0);
      chk(timer_active, 1'b0);
      chk(command, 4'h3);
      i_host.rd_r(ADDR_CNT_LO, d);
      chk(d, 8'h00);
      i_host.wr_r(ADDR_COMM, 8'h81);
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h01);
      i_host.wr_r(ADDR_COMM, 8'h01);
      i_host.rd_r(ADDR_COMM, d);
      chk(d, 8'h00);
      i_host.wr_r(ADDR_TMODE, 8'h81);
      i_host.wr_r(ADDR_TPRE, 8'hFF);
      #1 chk(timer_active, 1'b0);
      ev(4);
      repeat (2) @(posedge clk);
      #1 chk(timer_active, 1'b1);
      i_host.wr_r(ADDR_CTRL, 8'h80);
      $display("test timer done");
      i_host.wr_r(ADDR_THRESH, 8'h2A);
      i_host.wr_r(ADDR_CMD, 8'h10);
      #1 chk(osc_stop, 1'b1);
      i_host.wr_r(ADDR_CMD, 8'h00);
      #1 t0 = cyc;
      i_host.rd_r(ADDR_CMD, d);
      chk(d[CMD_SLEEP], 1'b1);
      for (k = 0; k < 1100 && osc_stop === 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk(cyc - t0 >= 1021 && cyc - t0 <= 1027, 1'b1);
      i_host.poll0(n);
      chk(n, 1);
      i_host.rd_r(ADDR_THRESH, d);
      chk(d, 8'h2A);
      $display("test sleep done");
      complete_run();
   end
endmodule
`default_nettype wire
